/* File: scc_pkg.sv */
/*
  constants for the sync, clamp and coast input control block:
  register offsets, field positions, reset values and timing counts.
  assumes a 20 MHz reference clock and an 8-bit register port.
*/
package scc_pkg;
  // register port widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [7:0] REG_CLK_CTRL    = 8'h03;
  localparam logic [7:0] REG_LINE_POL    = 8'h12;
  localparam logic [7:0] REG_FRAME_POL   = 8'h14;
  localparam logic [7:0] REG_CLAMP_CTRL  = 8'h18;
  localparam logic [7:0] REG_CLAMP_DELAY = 8'h19;
  localparam logic [7:0] REG_CLAMP_WIDTH = 8'h1A;
  localparam logic [7:0] REG_COAST_POL   = 8'h1B;
  localparam logic [7:0] REG_SLICE_THR   = 8'h1C;
  localparam logic [7:0] REG_PWR         = 8'h1E;
  localparam logic [7:0] REG_CHAN_SEL    = 8'h1F;
  localparam logic [7:0] REG_STATUS      = 8'h20;

  // field positions
  localparam int CLK_EXT_BIT    = 2;
  localparam int POL_OVR_BIT    = 5;
  localparam int POL_VAL_BIT    = 4;
  localparam int CLAMP_OVR_BIT  = 7;
  localparam int CLAMP_VAL_BIT  = 6;
  localparam int CLAMP_FN_BIT   = 4;
  localparam int COAST_OVR_BIT  = 7;
  localparam int COAST_VAL_BIT  = 6;
  localparam int PD_MANUAL_BIT  = 4;
  localparam int PD_FORCE_BIT   = 3;
  localparam int PD_PIN_POL_BIT = 2;
  localparam int CHAN_SEL_BIT   = 0;
  localparam int THR_W          = 5;

  // slicer threshold in millivolts
  localparam int THR_STEP_MV    = 8;
  localparam int THR_DEFAULT_MV = 128;

  // reset values
  localparam logic [7:0] RST_CLK_CTRL    = 8'h00;
  localparam logic [7:0] RST_LINE_POL    = 8'h00;
  localparam logic [7:0] RST_FRAME_POL   = 8'h00;
  localparam logic [7:0] RST_CLAMP_CTRL  = 8'h00;
  localparam logic [7:0] RST_CLAMP_DELAY = 8'h08;
  localparam logic [7:0] RST_CLAMP_WIDTH = 8'h0A;
  localparam logic [7:0] RST_COAST_POL   = 8'h40;
  localparam logic [7:0] RST_SLICE_THR   = 8'(THR_DEFAULT_MV / THR_STEP_MV - 1);
  localparam logic [7:0] RST_PWR         = 8'h04;
  localparam logic [7:0] RST_CHAN_SEL    = 8'h00;

  // synchroniser lane positions
  localparam int SYN_LS_A  = 0;
  localparam int SYN_LS_B  = 1;
  localparam int SYN_FS_A  = 2;
  localparam int SYN_FS_B  = 3;
  localparam int SYN_SOG_A = 4;
  localparam int SYN_SOG_B = 5;
  localparam int SYN_CLAMP = 6;
  localparam int SYN_COAST = 7;
  localparam int SYN_PD    = 8;
  localparam int SYN_W     = 9;

  // auto polarity observation window
  localparam int CLK_PERIOD_NS = 50;
  localparam int AUTO_WIN_NS   = 204800;
  localparam int AUTO_WIN_CYC  = AUTO_WIN_NS / CLK_PERIOD_NS;
  localparam logic [11:0] AUTO_WIN_LAST = 12'(AUTO_WIN_CYC - 1);
  localparam logic [12:0] AUTO_HALF     = 13'(AUTO_WIN_CYC / 2);
endpackage

/* File: scc_pol_if.sv */
/*
  carrier between the top block and one polarity detector.
  assumes the raw level is already synchronised to ref_clk.
*/
`timescale 1ns/10ps
interface scc_pol_if;
  logic raw;  // synchronised input level
  logic ovr;  // manual polarity override
  logic val;  // manual polarity, 1 = active high
  logic act;  // input normalised to active high
  logic pol;  // polarity in force
  modport det  (input raw, ovr, val, output act, pol);
  modport user (output raw, ovr, val, input act, pol);
endinterface

/* File: scc_pol_detect.sv */
/*
  automatic polarity detector for one sync, clamp or coast input.
  assumes a synchronised input; a short pulse marks the active level.
*/
`timescale 1ns/10ps
module scc_pol_detect (
  // clock and reset
  input  wire logic  ref_clk,
  input  wire logic  rst,
  // detector side of the carrier
  scc_pol_if.det     p
);
  logic [11:0] win_cnt_q;   // cycles in current window
  logic [11:0] win_cnt_d;
  logic [12:0] high_cnt_q;  // cycles spent high
  logic [12:0] high_cnt_d;
  logic        cand_q;      // candidate of last window
  logic        cand_d;
  logic        auto_pol_q;  // settled automatic polarity
  logic        auto_pol_d;
  logic        win_end;     // last cycle of a window
  logic [12:0] high_tot;    // high count including this cycle
  logic        cand_now;    // candidate of this window

  // window counting and stable decision
  always_comb
  begin
    win_end    = (win_cnt_q == scc_pkg::AUTO_WIN_LAST);
    high_tot   = high_cnt_q + 13'(p.raw);
    cand_now   = (high_tot < scc_pkg::AUTO_HALF); // mostly low: active high
    win_cnt_d  = win_cnt_q + 12'h001;
    high_cnt_d = high_tot;
    cand_d     = cand_q;
    auto_pol_d = auto_pol_q;
    if (win_end)
    begin
      win_cnt_d  = 12'h000;
      high_cnt_d = 13'h0000;
      cand_d     = cand_now;
      // two windows in a row must agree
      if (cand_now == cand_q)
        auto_pol_d = cand_now;
    end
  end

  // registers only
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      win_cnt_q  <= 12'h000;
      high_cnt_q <= 13'h0000;
      cand_q     <= 1'b1;
      auto_pol_q <= 1'b1;
    end
    else
    begin
      win_cnt_q  <= win_cnt_d;
      high_cnt_q <= high_cnt_d;
      cand_q     <= cand_d;
      auto_pol_q <= auto_pol_d;
    end
  end

  // manual field wins over detection
  assign p.pol = p.ovr ? p.val : auto_pol_q;
  assign p.act = p.raw ^ ~p.pol;

  // settled result moves only at a window end
  a_auto_pol_stable : assert property (@(posedge ref_clk) disable iff (rst)
    (auto_pol_q != $past(auto_pol_q)) |-> $past(win_end) && $past(cand_q) == auto_pol_q)
    else $error("auto polarity changed without two agreeing windows");
endmodule

/* File: scc_sync_ctrl.sv */
/*
  sync, clamp and coast input control: pin synchronisers, polarity
  handling, lock edge, internal clamp window, coast, field and power-down.
  assumes the pins are asynchronous to ref_clk and an 8-bit register port
  whose read data is taken one cycle after the read strobe.
*/
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
module scc_sync_ctrl (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [7:0]  reg_rdata,
  // sync and control pins
  input  wire logic        line_sync_in_a,
  input  wire logic        line_sync_in_b,
  input  wire logic        frame_sync_in_a,
  input  wire logic        frame_sync_in_b,
  input  wire logic        green_embedded_sync_in_a,
  input  wire logic        green_embedded_sync_in_b,
  input  wire logic        clamp_in,
  input  wire logic        external_pixel_clock_in,
  input  wire logic        power_down_pin,
  // outputs to the analog and clock sections
  output logic             green_sync_slicer_out,
  output logic      [4:0]  slicer_threshold_code,
  output logic             line_sync_lock_pulse,
  output logic             clamp_active,
  output logic             coast_active,
  output logic             pixel_clock_ext_sel,
  output logic             odd_even_field,
  output logic             power_down
);
  // clamp window states
  typedef enum logic [2:0] {
    SCC_CL_IDLE  = 3'b001,
    SCC_CL_DELAY = 3'b010,
    SCC_CL_WIN   = 3'b100
  } scc_clamp_st_t;

  // register file
  logic [7:0] clk_ctrl_q,    clk_ctrl_d;     // external clock select
  logic [7:0] line_pol_q,    line_pol_d;     // line sync polarity
  logic [7:0] frame_pol_q,   frame_pol_d;    // frame sync polarity
  logic [7:0] clamp_ctrl_q,  clamp_ctrl_d;   // clamp enable and polarity
  logic [7:0] clamp_dly_q,   clamp_dly_d;    // internal clamp delay
  logic [7:0] clamp_wid_q,   clamp_wid_d;    // internal clamp width
  logic [7:0] coast_pol_q,   coast_pol_d;    // coast polarity
  logic [7:0] slice_thr_q,   slice_thr_d;    // slicer threshold code
  logic [7:0] pwr_q,         pwr_d;          // power-down control
  logic [7:0] chan_q,        chan_d;         // input set select
  logic [7:0] rdata_q,       rdata_d;        // read data register

  // synchronisers
  logic [scc_pkg::SYN_W-1:0] sync1_q;  // first stage, read only by sync2
  logic [scc_pkg::SYN_W-1:0] sync2_q;  // second stage
  logic [scc_pkg::SYN_W-1:0] pins;     // pin vector

  // sync processing
  logic        chan_b;                  // input set 1 selected
  logic        ls_act_q,  fs_act_q;     // previous active levels
  logic        ls_lead, ls_trail;       // line sync edges
  logic        fs_lead;                 // frame sync leading edge
  logic        coast_any;               // external or internal coast
  logic        lock_q,    lock_d;       // lock edge pulse
  logic        coast_q,   coast_d;      // registered coast
  logic        sog_q,     sog_d;        // slicer output
  logic [15:0] line_cnt_q, line_cnt_d;  // cycles since line lead
  logic [15:0] line_len_q, line_len_d;  // last line length
  logic        field_q,   field_d;      // odd/even field
  logic        pd_q,      pd_d;         // power-down output
  logic        pd_pin_act;              // pin in its active sense
  scc_clamp_st_t clamp_st_q, clamp_st_d;  // clamp window state
  logic [7:0]  clamp_cnt_q, clamp_cnt_d;  // clamp window counter
  logic        clamp_q,   clamp_d;        // clamp output

  // polarity carriers
  scc_pol_if line_p ();
  scc_pol_if frame_p ();
  scc_pol_if clamp_p ();
  scc_pol_if coast_p ();

  // pin vector in lane order
  assign pins = {power_down_pin, external_pixel_clock_in, clamp_in,
                 green_embedded_sync_in_b, green_embedded_sync_in_a,
                 frame_sync_in_b, frame_sync_in_a,
                 line_sync_in_b, line_sync_in_a};

  // two-stage synchroniser for every pin
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
    end
  end

  // input set select for all three syncs
  assign chan_b = chan_q[scc_pkg::CHAN_SEL_BIT];
  assign line_p.raw  = chan_b ? sync2_q[scc_pkg::SYN_LS_B] : sync2_q[scc_pkg::SYN_LS_A];
  assign frame_p.raw = chan_b ? sync2_q[scc_pkg::SYN_FS_B] : sync2_q[scc_pkg::SYN_FS_A];
  assign clamp_p.raw = sync2_q[scc_pkg::SYN_CLAMP];
  // shared pin sampled as coast whatever the clock select
  assign coast_p.raw = sync2_q[scc_pkg::SYN_COAST];

  // manual polarity fields
  assign line_p.ovr  = line_pol_q[scc_pkg::POL_OVR_BIT];
  assign line_p.val  = line_pol_q[scc_pkg::POL_VAL_BIT];
  assign frame_p.ovr = frame_pol_q[scc_pkg::POL_OVR_BIT];
  assign frame_p.val = frame_pol_q[scc_pkg::POL_VAL_BIT];
  assign clamp_p.ovr = clamp_ctrl_q[scc_pkg::CLAMP_OVR_BIT];
  assign clamp_p.val = clamp_ctrl_q[scc_pkg::CLAMP_VAL_BIT];
  assign coast_p.ovr = coast_pol_q[scc_pkg::COAST_OVR_BIT];
  assign coast_p.val = coast_pol_q[scc_pkg::COAST_VAL_BIT];

  // one detector per line sync, frame sync, clamp and coast input; the embedded syncs have none
  scc_pol_detect u_line_pol  (.ref_clk(ref_clk), .rst(rst), .p(line_p.det));
  scc_pol_detect u_frame_pol (.ref_clk(ref_clk), .rst(rst), .p(frame_p.det));
  scc_pol_detect u_clamp_pol (.ref_clk(ref_clk), .rst(rst), .p(clamp_p.det));
  scc_pol_detect u_coast_pol (.ref_clk(ref_clk), .rst(rst), .p(coast_p.det));

  // edges of the normalised syncs; polarity 0 makes falling active
  assign ls_lead   = line_p.act & ~ls_act_q;
  assign ls_trail  = ~line_p.act & ls_act_q;
  assign fs_lead   = frame_p.act & ~fs_act_q;
  // frame sync pulse doubles as internal coast
  assign coast_any = coast_p.act | frame_p.act;

  // pin level in its programmed sense, 1 = active high
  function automatic logic power_down_pin_level(input logic lvl, input logic hi);
    power_down_pin_level = hi ? lvl : ~lvl;
  endfunction
  assign pd_pin_act = power_down_pin_level(sync2_q[scc_pkg::SYN_PD],
                                           pwr_q[scc_pkg::PD_PIN_POL_BIT]);

  // sync, field, coast and power-down next values
  always_comb
  begin
    // lock only on leading edge, held off by coast
    lock_d     = ls_lead & ~coast_any;
    coast_d    = coast_any;
    // noninverted embedded sync of the chosen set
    sog_d      = chan_b ? sync2_q[scc_pkg::SYN_SOG_B] : sync2_q[scc_pkg::SYN_SOG_A];
    line_cnt_d = (line_cnt_q == 16'hFFFF) ? line_cnt_q : line_cnt_q + 16'h0001;
    line_len_d = line_len_q;
    field_d    = field_q;
    if (ls_lead)
    begin
      line_len_d = line_cnt_q;
      line_cnt_d = 16'h0000;
    end
    // field from frame edge position within the line
    if (fs_lead)
      field_d = (line_cnt_q > {1'b0, line_len_q[15:1]});
    // manual power-down from bit or pin
    pd_d = pwr_q[scc_pkg::PD_MANUAL_BIT] & (pwr_q[scc_pkg::PD_FORCE_BIT] | pd_pin_act);
  end

  // internal clamp window from the trailing edge
  always_comb
  begin
    clamp_st_d  = clamp_st_q;
    clamp_cnt_d = clamp_cnt_q;
    case (clamp_st_q)
      SCC_CL_IDLE:
      begin
        clamp_cnt_d = clamp_cnt_q;
      end
      SCC_CL_DELAY:
      begin
        // count out the delay
        if (clamp_cnt_q == 8'h00)
        begin
          clamp_st_d  = SCC_CL_WIN;
          clamp_cnt_d = clamp_wid_q;
        end
        else
          clamp_cnt_d = clamp_cnt_q - 8'h01;
      end
      SCC_CL_WIN:
      begin
        // count out the width
        if (clamp_cnt_q == 8'h00)
          clamp_st_d = SCC_CL_IDLE;
        else
          clamp_cnt_d = clamp_cnt_q - 8'h01;
      end
      default:
      begin
        clamp_st_d  = SCC_CL_IDLE;
        clamp_cnt_d = 8'h00;
      end
    endcase
    // every trailing edge restarts the delay
    if (ls_trail)
    begin
      clamp_st_d  = SCC_CL_DELAY;
      clamp_cnt_d = clamp_dly_q;
    end
    // external pin only when enabled
    clamp_d = clamp_ctrl_q[scc_pkg::CLAMP_FN_BIT] ? clamp_p.act
                                                  : (clamp_st_q == SCC_CL_WIN);
  end

  // register writes and read data
  always_comb
  begin
    clk_ctrl_d   = clk_ctrl_q;
    line_pol_d   = line_pol_q;
    frame_pol_d  = frame_pol_q;
    clamp_ctrl_d = clamp_ctrl_q;
    clamp_dly_d  = clamp_dly_q;
    clamp_wid_d  = clamp_wid_q;
    coast_pol_d  = coast_pol_q;
    slice_thr_d  = slice_thr_q;
    pwr_d        = pwr_q;
    chan_d       = chan_q;
    rdata_d      = 8'h00;
    if (reg_write)
    begin
      case (reg_addr)
        scc_pkg::REG_CLK_CTRL:    clk_ctrl_d   = reg_wdata;
        scc_pkg::REG_LINE_POL:    line_pol_d   = reg_wdata;
        scc_pkg::REG_FRAME_POL:   frame_pol_d  = reg_wdata;
        scc_pkg::REG_CLAMP_CTRL:  clamp_ctrl_d = reg_wdata;
        scc_pkg::REG_CLAMP_DELAY: clamp_dly_d  = reg_wdata;
        scc_pkg::REG_CLAMP_WIDTH: clamp_wid_d  = reg_wdata;
        scc_pkg::REG_COAST_POL:   coast_pol_d  = reg_wdata;
        // threshold code field only
        scc_pkg::REG_SLICE_THR:   slice_thr_d  = {3'h0, reg_wdata[scc_pkg::THR_W-1:0]};
        scc_pkg::REG_PWR:         pwr_d        = reg_wdata;
        scc_pkg::REG_CHAN_SEL:    chan_d       = reg_wdata;
        default:                  chan_d       = chan_q;
      endcase
    end
    if (reg_read)
    begin
      case (reg_addr)
        scc_pkg::REG_CLK_CTRL:    rdata_d = clk_ctrl_q;
        scc_pkg::REG_LINE_POL:    rdata_d = line_pol_q;
        scc_pkg::REG_FRAME_POL:   rdata_d = frame_pol_q;
        scc_pkg::REG_CLAMP_CTRL:  rdata_d = clamp_ctrl_q;
        scc_pkg::REG_CLAMP_DELAY: rdata_d = clamp_dly_q;
        scc_pkg::REG_CLAMP_WIDTH: rdata_d = clamp_wid_q;
        scc_pkg::REG_COAST_POL:   rdata_d = coast_pol_q;
        scc_pkg::REG_SLICE_THR:   rdata_d = slice_thr_q;
        scc_pkg::REG_PWR:         rdata_d = pwr_q;
        scc_pkg::REG_CHAN_SEL:    rdata_d = chan_q;
        // live polarities and field
        scc_pkg::REG_STATUS:      rdata_d = {3'h0, field_q, coast_p.pol, clamp_p.pol,
                                             frame_p.pol, line_p.pol};
        default:                  rdata_d = 8'h00;
      endcase
    end
  end

  // all block state registers except the synchronisers
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      clk_ctrl_q   <= scc_pkg::RST_CLK_CTRL;
      line_pol_q   <= scc_pkg::RST_LINE_POL;
      frame_pol_q  <= scc_pkg::RST_FRAME_POL;
      clamp_ctrl_q <= scc_pkg::RST_CLAMP_CTRL;
      clamp_dly_q  <= scc_pkg::RST_CLAMP_DELAY;
      clamp_wid_q  <= scc_pkg::RST_CLAMP_WIDTH;
      coast_pol_q  <= scc_pkg::RST_COAST_POL;
      slice_thr_q  <= scc_pkg::RST_SLICE_THR;
      pwr_q        <= scc_pkg::RST_PWR;
      chan_q       <= scc_pkg::RST_CHAN_SEL;
      rdata_q      <= 8'h00;
      ls_act_q     <= 1'b0;
      fs_act_q     <= 1'b0;
      lock_q       <= 1'b0;
      coast_q      <= 1'b0;
      sog_q        <= 1'b0;
      line_cnt_q   <= 16'h0000;
      line_len_q   <= 16'h0000;
      field_q      <= 1'b0;
      pd_q         <= 1'b0;
      clamp_st_q   <= SCC_CL_IDLE;
      clamp_cnt_q  <= 8'h00;
      clamp_q      <= 1'b0;
    end
    else
    begin
      clk_ctrl_q   <= clk_ctrl_d;
      line_pol_q   <= line_pol_d;
      frame_pol_q  <= frame_pol_d;
      clamp_ctrl_q <= clamp_ctrl_d;
      clamp_dly_q  <= clamp_dly_d;
      clamp_wid_q  <= clamp_wid_d;
      coast_pol_q  <= coast_pol_d;
      slice_thr_q  <= slice_thr_d;
      pwr_q        <= pwr_d;
      chan_q       <= chan_d;
      rdata_q      <= rdata_d;
      ls_act_q     <= line_p.act;
      fs_act_q     <= frame_p.act;
      lock_q       <= lock_d;
      coast_q      <= coast_d;
      sog_q        <= sog_d;
      line_cnt_q   <= line_cnt_d;
      line_len_q   <= line_len_d;
      field_q      <= field_d;
      pd_q         <= pd_d;
      clamp_st_q   <= clamp_st_d;
      clamp_cnt_q  <= clamp_cnt_d;
      clamp_q      <= clamp_d;
    end
  end

  // outputs straight from registers
  assign reg_rdata             = rdata_q;
  assign green_sync_slicer_out = sog_q;
  assign slicer_threshold_code = slice_thr_q[scc_pkg::THR_W-1:0];
  assign line_sync_lock_pulse  = lock_q;
  assign clamp_active          = clamp_q;
  assign coast_active          = coast_q;
  assign pixel_clock_ext_sel   = clk_ctrl_q[scc_pkg::CLK_EXT_BIT];
  assign odd_even_field        = field_q;
  assign power_down            = pd_q;

  // edge sequences
  sequence s_line_lead;
    !line_p.act ##1 line_p.act;
  endsequence
  sequence s_line_trail;
    line_p.act ##1 !line_p.act;
  endsequence

  a_lock_on_lead : assert property (@(posedge ref_clk) disable iff (rst)
    line_sync_lock_pulse |-> $past(line_p.act) && !$past(line_p.act, 2))
    else $error("lock pulse without a leading edge");
  a_lock_edge_seen : assert property (@(posedge ref_clk) disable iff (rst)
    (s_line_lead ##0 !coast_any) |=> line_sync_lock_pulse)
    else $error("leading edge missed by lock pulse");
  a_coast_blocks_lock : assert property (@(posedge ref_clk) disable iff (rst)
    coast_active |-> !line_sync_lock_pulse)
    else $error("lock pulse while coasting");
  a_clamp_ext_pass : assert property (@(posedge ref_clk) disable iff (rst)
    (clamp_ctrl_q[scc_pkg::CLAMP_FN_BIT] && clamp_p.act) |=> clamp_active)
    else $error("enabled external clamp not passed");
  a_clamp_trail_start : assert property (@(posedge ref_clk) disable iff (rst)
    s_line_trail |=> clamp_st_q == SCC_CL_DELAY && clamp_cnt_q == $past(clamp_dly_q))
    else $error("trailing edge did not start clamp delay");
  a_clamp_idle_off : assert property (@(posedge ref_clk) disable iff (rst)
    (!clamp_ctrl_q[scc_pkg::CLAMP_FN_BIT] && clamp_st_q != SCC_CL_WIN) |=> !clamp_active)
    else $error("internal clamp active outside its window");
  a_ext_clk_write : assert property (@(posedge ref_clk) disable iff (rst)
    (reg_write && reg_addr == scc_pkg::REG_CLK_CTRL)
      |=> pixel_clock_ext_sel == $past(reg_wdata[scc_pkg::CLK_EXT_BIT]))
    else $error("clock select did not follow write");
  a_slicer_noninv : assert property (@(posedge ref_clk) disable iff (rst)
    ($past(chan_b) == chan_b && !$past(rst) && !$past(rst, 2) && !$past(rst, 3))
      |-> green_sync_slicer_out == (chan_b ? $past(green_embedded_sync_in_b, 3)
                                           : $past(green_embedded_sync_in_a, 3)))
    else $error("slicer output not the selected sync");
  a_pd_manual_only : assert property (@(posedge ref_clk) disable iff (rst)
    !$past(pwr_q[scc_pkg::PD_MANUAL_BIT]) |-> !power_down)
    else $error("power-down without manual select");
  a_field_on_frame : assert property (@(posedge ref_clk) disable iff (rst)
    (field_q != $past(field_q)) |-> $past(fs_lead))
    else $error("field changed without frame edge");
  a_reset_defaults : assert property (@(posedge ref_clk)
    ($past(rst) && !rst) |-> coast_pol_q[scc_pkg::COAST_VAL_BIT] == 1'b1
                             && slicer_threshold_code == 5'h0F
                             && !clamp_ctrl_q[scc_pkg::CLAMP_FN_BIT])
    else $error("wrong reset defaults");
endmodule

/* File: scc_sync_src.sv */
/*
  source model: periodic line sync and optional frame pulse on one of two
  pin sets, optional back porch clamp on the single clamp pin.
  assumes ref_clk comes from the bench.
*/
`timescale 1ns/10ps
module scc_sync_src (
  // clock and set select
  input  wire logic ref_clk,
  input  wire logic       sel,
  // frame pulse enable and start phase, clamp enable
  input  wire logic       fen,
  input  wire logic [6:0] fph,
  input  wire logic       cen,
  // sync and clamp pins
  output logic            ls_a = 1'b0,
  output logic            ls_b = 1'b0,
  output logic            fs_a = 1'b0,
  output logic            fs_b = 1'b0,
  output logic            cl   = 1'b0
);
  int ph = 0;  // position in the line
  // 100 cycle line, active high pulse of 20, unused set held low
  always @(posedge ref_clk)
  begin
    ph <= (ph == 99) ? 0 : ph + 1;
    ls_a <= !sel && ph < 20;
    ls_b <= sel && ph < 20;
    // five cycle frame pulse from the chosen phase
    fs_a <= !sel && fen && ph >= fph && ph < fph + 5;
    fs_b <= sel && fen && ph >= fph && ph < fph + 5;
    // clamp only in the back porch
    cl <= cen && ph >= 25 && ph < 35;
  end
endmodule

/* File: test_sync_clamp_coast_input_control.sv */
/*
  bench for the sync, clamp and coast input control block.
  assumes the source model drives the line sync, frame sync and clamp pins.
*/
`timescale 1ns/10ps
module test_sync_clamp_coast_input_control;
  logic ref_clk = 0, rst = 1, wr = 0, rd = 0, sel = 0, gs = 0, ex = 0, pd = 0;
  logic fen = 0, cen = 0;
  logic [6:0] fph = 0;
  logic [7:0] a = 0, wd = 0, rdata;
  logic ls_a, ls_b, fs_a, fs_b, cl, slo, lk, ca, co, xs, oe, pw;
  logic [4:0] thr;
  int err_count = 0, num_checks = 0, cyc = 0, l, c;
  scc_sync_src SRC (.ref_clk, .sel, .fen, .fph, .cen, .ls_a, .ls_b, .fs_a, .fs_b, .cl);
  scc_sync_ctrl DUT (.ref_clk, .rst, .reg_addr(a), .reg_wdata(wd), .reg_write(wr),
    .reg_read(rd), .reg_rdata(rdata), .line_sync_in_a(ls_a), .line_sync_in_b(ls_b),
    .frame_sync_in_a(fs_a), .frame_sync_in_b(fs_b), .green_embedded_sync_in_a(gs),
    .green_embedded_sync_in_b(1'b0), .clamp_in(cl), .external_pixel_clock_in(ex),
    .power_down_pin(pd), .green_sync_slicer_out(slo), .slicer_threshold_code(thr),
    .line_sync_lock_pulse(lk), .clamp_active(ca), .coast_active(co),
    .pixel_clock_ext_sel(xs), .odd_even_field(oe), .power_down(pw));
  initial forever #25 ref_clk = !ref_clk;
  // hang guard
  always @(posedge ref_clk) if (++cyc > 20000) begin err_count++; results; end
  task results;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input string n, input logic [7:0] e, g);
    num_checks++;
    if (e !== g) begin err_count++; $display("BAD %s exp %h got %h", n, e, g); end
  endtask
  task st(input int n); repeat (n) @(posedge ref_clk); endtask
  task wreg(input logic [7:0] ad, d); wr <= 1; a <= ad; wd <= d; st(1); wr <= 0; st(1); endtask
  task rchk(input logic [7:0] ad, e); rd <= 1; a <= ad; st(1); rd <= 0; st(1);
    chk("rdata", e, rdata); endtask
  // lock pulses and clamp cycles over n cycles
  task cnt(input int n); l = 0; c = 0;
    repeat (n) begin st(1); l += lk; c += ca; end endtask
  task t_reset; chk("thr", 8'h0F, 8'(thr));
    rchk(8'h1C, 8'h0F);
    rchk(8'h1B, 8'h40);
    rchk(8'h18, 8'h00);
    rchk(8'h40, 8'h00); endtask
  task t_slice; gs <= 1; st(5); chk("slicer", 8'h01, 8'(slo));
    wreg(8'h1C, 8'hFF); st(2); chk("thr", 8'h1F, 8'(thr));
    rchk(8'h1C, 8'h1F); endtask
  // lock pulses right after the rising pin edge, then around the falling one
  task lead(input logic [7:0] e, f); @(posedge ls_a); cnt(8); chk("lead", e, 8'(l));
    cnt(22); chk("trail", f, 8'(l)); endtask
  task t_pol; wreg(8'h12, 8'h30); st(150); lead(8'h01, 8'h00);
    wreg(8'h12, 8'h20); st(150); lead(8'h00, 8'h01); endtask
  task t_clamp; cnt(100); chk("clamp", 8'h0B, 8'(c));
    wreg(8'h18, 8'hD0); cen <= 1; st(10); cnt(100); chk("xclamp", 8'h0A, 8'(c));
    wreg(8'h18, 8'h90); st(10); cnt(100); chk("xclamp", 8'h5A, 8'(c));
    wreg(8'h18, 8'h00); cen <= 0; endtask
  task t_chan; sel <= 1; st(150); cnt(100); chk("chan", 8'h00, 8'(l));
    wreg(8'h1F, 8'h01); st(150); cnt(100); chk("chan", 8'h01, 8'(l));
    chk("slicer", 8'h00, 8'(slo)); endtask
  // coast pin held high until the automatic sense turns it over
  task t_auto; wreg(8'h1B, 8'h40); ex <= 1; st(10); chk("coast", 8'h01, 8'(co));
    st(12300); chk("coast", 8'h00, 8'(co));
    rchk(8'h20, 8'h06);
    ex <= 0; wreg(8'h1B, 8'hC0); endtask
  // frame pulse early, late, then on the line edge as internal coast
  task t_field; wreg(8'h12, 8'h30); fph <= 7'h0A; fen <= 1; st(250);
    chk("field", 8'h00, 8'(oe));
    cnt(100); chk("lock", 8'h01, 8'(l));
    fph <= 7'h46; st(200); chk("field", 8'h01, 8'(oe));
    fph <= 7'h00; st(200); cnt(100); chk("lock", 8'h00, 8'(l));
    fen <= 0; endtask
  task t_coast; wreg(8'h1B, 8'hC0); wreg(8'h14, 8'h30); wreg(8'h03, 8'h04); st(150);
    chk("extsel", 8'h01, 8'(xs));
    cnt(100); chk("lock", 8'h01, 8'(l));
    ex <= 1; st(10); chk("coast", 8'h01, 8'(co));
    cnt(100); chk("lock", 8'h00, 8'(l)); ex <= 0; endtask
  task t_pd; wreg(8'h1E, 8'h14); st(5); chk("pd", 8'h00, 8'(pw));
    pd <= 1; st(5); chk("pd", 8'h01, 8'(pw));
    wreg(8'h1E, 8'h0C); st(5); chk("pd", 8'h00, 8'(pw));
    wreg(8'h1E, 8'h18); pd <= 0; st(5); chk("pd", 8'h01, 8'(pw));
    wreg(8'h1E, 8'h10); st(5); chk("pd", 8'h01, 8'(pw));
    wreg(8'h1E, 8'h14); endtask
  initial
  begin
    st(16); rst <= 0; st(1);
    t_reset; t_slice; t_pol; t_clamp; t_chan; t_coast; t_auto; t_field; t_pd;
    results;
  end
endmodule
